//--- joystick_button_motion_control.sv
`timescale 1ns/1ps

// Operation
// - Joystick value: 0 V is 0, 3 V 10000
// - Inside dead band the joystick commands stop
// - Speed curve from deviation; zero gives linear
// - Reverse flag inverts joystick direction
// - Ten-entry shared table; right press advances index
// - Never enter zero entry nor leave table
// - Button press counts after over 3 ms
// - After 5 s idle, leaving needs 100 ms
// - Leaving band cancels host motion, joystick takes over
// - Joystick motion uses normal motion settings
// - Button active level programmable per button
// - Click gives relative shift by click offset
// - Hold runs table speeds, stepping per stage
// - Step only if next speed, stage time nonzero
// - Both buttons stop; 3 s held homes
// - Speed change ramps, or jumps without acceleration
// - Button active at start counts as press
// - Settings written and read back by paired commands
module joystick_button_motion_control
    import joystick_button_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
    parameter int LONG_IDLE_CYCLES = LONG_IDLE_CYC,
    parameter int LEAVE_CYCLES = LEAVE_CYC,
    parameter int HOME_CYCLES = HOME_HOLD_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Joystick sample from the converter, same clock
    input wire logic [13:0] joyValue,
    input wire joy_cfg_t joyCfg,
    // Button pins, asynchronous
    input wire logic btnLeftPin,
    input wire logic btnRightPin,
    // Settings commands
    input wire logic writeControlSettingsCmd,
    input wire ctl_settings_t ctlSettingsIn,
    input wire logic readControlSettingsCmd,
    output ctl_settings_t ctlSettingsOut,
    output logic ctlReadValid,
    // Shared motion settings and host state
    input wire logic accelEnable,
    input wire logic [15:0] accelPerUs,
    input wire logic hostBusy,
    // Requests toward the motion generator
    output motion_t speedCmd,
    output logic shiftReq,
    output logic shiftRight,
    output logic [31:0] shiftSteps,
    output logic [7:0] shiftMicrosteps,
    output logic stopReq,
    output logic homeReq,
    output logic cancelHostCmd,
    output logic joyActive,
    output logic [3:0] tableIndex
);

    // Whole block state in one record
    typedef struct packed {
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [1:0][31:0] dbCnt;
        logic [1:0] btn;
        logic [1:0] btnPrev;
        ctl_settings_t ctl;
        ctl_settings_t readback;
        logic readValid;
        logic [6:0] usCnt;
        logic [3:0] idx;
        btn_state_t bst;
        logic [31:0] holdUs;
        logic [3:0] stage;
        logic [31:0] bothCnt;
        logic runRight;
        logic [31:0] inCnt;
        logic [31:0] outCnt;
        logic longIn;
        logic joyOut;
        logic joyAbove;
        logic joyMode;
        logic joyAct;
        logic cancelHost;
        logic stopPulse;
        logic homePulse;
        logic shiftPulse;
        logic shiftDir;
        motion_t target;
        motion_t cmd;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    // Joystick shaping terms, combinational
    logic [13:0] dev;
    logic [13:0] span;
    logic [20:0] bandScaled;
    logic [13:0] band;
    logic [24:0] fracWide;
    logic [10:0] frac;
    logic [21:0] bend;
    logic [10:0] curve;
    logic [26:0] joySpeed;
    logic inBand;
    logic [1:0] active;
    logic usTick;
    logic bothDown;
    logic anyDown;
    speed_table_entry_t nextEntry;

    // Dead band and speed curve for the current sample
    always_comb begin
        // Deviation and side span from the centre point
        if (joyValue > joyCfg.centerPt) begin
            dev = joyValue - joyCfg.centerPt;
            span = joyCfg.highPt - joyCfg.centerPt;
        end else begin
            dev = joyCfg.centerPt - joyValue;
            span = joyCfg.centerPt - joyCfg.lowPt;
        end
        // Band is a percentage of the span on this side
        // Widen before the product so a full span times 100 fits
        bandScaled = 21'(span) * 21'(joyCfg.deadZonePct);
        band = 14'(bandScaled / 21'(PCT_FULL));
        inBand = (dev <= band);
        // Normalised deviation beyond the band, 0..1024
        if (inBand || span <= band) begin
            fracWide = '0;
        end else begin
            fracWide = 25'((25'(dev - band) << FRAC_BITS) / 25'(span - band));
        end
        frac = (fracWide > 25'(FRAC_ONE)) ? FRAC_ONE : fracWide[10:0];
        // Bend toward a steep curve; zero setting stays linear
        bend = (22'(frac) * 22'(FRAC_ONE - frac)) >> FRAC_BITS;
        curve = frac - 11'((bend * 22'(joyCfg.nonlinearity)) / (22'(NONLIN_FULL) + 22'h1));
        joySpeed = (27'(st_r.ctl.speedTable[st_r.idx].steps) * 27'(curve)) >> FRAC_BITS;
    end

    // Button helpers from the registered state
    always_comb begin
        usTick = (st_r.usCnt == 7'(US_CYCLES - 1));
        bothDown = st_r.btn[BTN_LEFT] && st_r.btn[BTN_RIGHT];
        anyDown = st_r.btn[BTN_LEFT] || st_r.btn[BTN_RIGHT];
        nextEntry = (st_r.idx < LAST_INDEX) ? st_r.ctl.speedTable[st_r.idx + 4'h1] : '0;
        // Pin level against programmed active level
        active = ~(st_r.sync2 ^ st_r.ctl.btnActiveHigh);
    end

    // Next-state logic for the whole block
    always_comb begin
        st_nxt = st_r;
        st_nxt.sync1 = {btnRightPin, btnLeftPin};
        st_nxt.sync2 = st_r.sync1;
        st_nxt.btnPrev = st_r.btn;
        st_nxt.readValid = 1'b0;
        st_nxt.cancelHost = 1'b0;
        st_nxt.stopPulse = 1'b0;
        st_nxt.homePulse = 1'b0;
        st_nxt.shiftPulse = 1'b0;
        st_nxt.joyMode = joyCfg.enable;
        st_nxt.usCnt = usTick ? 7'h00 : st_r.usCnt + 7'h01;

        // Settings write and read back
        if (writeControlSettingsCmd) begin
            st_nxt.ctl = ctlSettingsIn;
        end
        if (readControlSettingsCmd) begin
            st_nxt.readback = st_r.ctl;
            st_nxt.readValid = 1'b1;
        end

        // Debounce: press after active for longer than the limit
        // Released state at reset turns a held button into a press
        for (int i = 0; i < 2; i++) begin
            if (!active[i]) begin
                st_nxt.dbCnt[i] = '0;
                st_nxt.btn[i] = 1'b0;
            end else if (st_r.dbCnt[i] > 32'(DEBOUNCE_CYCLES)) begin
                st_nxt.btn[i] = 1'b1;
            end else begin
                st_nxt.dbCnt[i] = st_r.dbCnt[i] + 32'h1;
            end
        end

        // Dead band dwell and leave filtering
        if (inBand) begin
            st_nxt.outCnt = '0;
            st_nxt.joyOut = 1'b0;
            if (st_r.inCnt > 32'(LONG_IDLE_CYCLES)) begin
                st_nxt.longIn = 1'b1;
            end else begin
                st_nxt.inCnt = st_r.inCnt + 32'h1;
            end
        end else begin
            st_nxt.inCnt = '0;
            if (!st_r.longIn || st_r.outCnt > 32'(LEAVE_CYCLES)) begin
                st_nxt.joyOut = 1'b1;
                st_nxt.longIn = 1'b0;
            end else begin
                st_nxt.outCnt = st_r.outCnt + 32'h1;
            end
        end
        st_nxt.joyAbove = (joyValue > joyCfg.centerPt);
        // Registered so the output comes from one flop
        st_nxt.joyAct = st_nxt.joyOut && joyCfg.enable;

        if (joyCfg.enable) begin
            // Host motion is dropped when the stick takes over
            if (st_nxt.joyOut && !st_r.joyOut && hostBusy) begin
                st_nxt.cancelHost = 1'b1;
            end
            // Speed request, stop inside the band
            st_nxt.target.moving = st_nxt.joyOut && (joySpeed != '0);
            st_nxt.target.dirRight = st_nxt.joyAbove ^ joyCfg.reverse;
            st_nxt.target.speed.steps = st_nxt.joyOut ? joySpeed[15:0] : 16'h0000;
            st_nxt.target.speed.microsteps = 8'h00;
            // Table index stepping on fresh presses
            if (st_r.btn[BTN_RIGHT] && !st_r.btnPrev[BTN_RIGHT]) begin
                if (st_r.idx < LAST_INDEX && nextEntry != '0) begin
                    st_nxt.idx = st_r.idx + 4'h1;
                end
            end else if (st_r.btn[BTN_LEFT] && !st_r.btnPrev[BTN_LEFT]) begin
                if (st_r.idx != 4'h0) begin
                    st_nxt.idx = st_r.idx - 4'h1;
                end
            end
            st_nxt.bst = B_WAIT;
        end else begin
            // Button sequencer
            case (st_r.bst)
                B_IDLE: begin
                    st_nxt.target.moving = 1'b0;
                    if (bothDown) begin
                        st_nxt.bst = B_BOTH;
                        st_nxt.bothCnt = '0;
                        st_nxt.stopPulse = 1'b1;
                    end else if (anyDown) begin
                        st_nxt.bst = B_PRESS;
                        st_nxt.holdUs = '0;
                        st_nxt.runRight = st_r.btn[BTN_RIGHT];
                    end
                end
                B_PRESS: begin
                    if (bothDown) begin
                        st_nxt.bst = B_BOTH;
                        st_nxt.bothCnt = '0;
                        st_nxt.stopPulse = 1'b1;
                    end else if (!anyDown) begin
                        // Short click: relative shift
                        st_nxt.shiftPulse = 1'b1;
                        st_nxt.shiftDir = st_r.runRight;
                        st_nxt.bst = B_IDLE;
                    end else if (st_r.holdUs > st_r.ctl.clickLengthLimit) begin
                        // Long hold: run at the first table speed
                        st_nxt.bst = B_HOLD;
                        st_nxt.stage = 4'h0;
                        st_nxt.holdUs = '0;
                        st_nxt.target.moving = 1'b1;
                        st_nxt.target.dirRight = st_r.runRight;
                        st_nxt.target.speed = st_r.ctl.speedTable[0];
                    end else if (usTick) begin
                        st_nxt.holdUs = st_r.holdUs + 32'h1;
                    end
                end
                B_HOLD: begin
                    if (bothDown) begin
                        st_nxt.bst = B_BOTH;
                        st_nxt.bothCnt = '0;
                        st_nxt.stopPulse = 1'b1;
                        st_nxt.target.moving = 1'b0;
                    end else if (!anyDown) begin
                        st_nxt.bst = B_IDLE;
                        st_nxt.target.moving = 1'b0;
                    end else if (usTick) begin
                        st_nxt.holdUs = st_r.holdUs + 32'h1;
                        // Stage advance guarded by nonzero terms
                        if (st_r.stage < LAST_INDEX
                            && st_r.ctl.stageTimeoutUs[st_r.stage] != '0
                            && st_r.holdUs + 32'h1 >= st_r.ctl.stageTimeoutUs[st_r.stage]
                            && st_r.ctl.speedTable[st_r.stage + 4'h1] != '0) begin
                            st_nxt.stage = st_r.stage + 4'h1;
                            st_nxt.holdUs = '0;
                            st_nxt.target.speed = st_r.ctl.speedTable[st_r.stage + 4'h1];
                        end
                    end
                end
                B_BOTH: begin
                    st_nxt.target.moving = 1'b0;
                    if (!bothDown) begin
                        st_nxt.bst = B_WAIT;
                    end else if (st_r.bothCnt >= 32'(HOME_CYCLES - 1)) begin
                        st_nxt.homePulse = 1'b1;
                        st_nxt.bst = B_WAIT;
                    end else begin
                        st_nxt.bothCnt = st_r.bothCnt + 32'h1;
                    end
                end
                B_WAIT: begin
                    // Wait for full release before a new gesture
                    st_nxt.target.moving = 1'b0;
                    if (!anyDown) begin
                        st_nxt.bst = B_IDLE;
                    end
                end
                default: begin
                    st_nxt.bst = B_IDLE;
                end
            endcase
        end

        // Shared acceleration stage for both sources
        if (!accelEnable) begin
            st_nxt.cmd = st_r.target;
        end else if (usTick) begin
            if (!st_r.target.moving || st_r.cmd.dirRight != st_r.target.dirRight) begin
                // Slow to rest before stopping or reversing
                if (st_r.cmd.speed.steps > accelPerUs) begin
                    st_nxt.cmd.speed.steps = st_r.cmd.speed.steps - accelPerUs;
                end else begin
                    st_nxt.cmd.speed = '0;
                    st_nxt.cmd.moving = st_r.target.moving;
                    st_nxt.cmd.dirRight = st_r.target.dirRight;
                end
            end else begin
                st_nxt.cmd.moving = 1'b1;
                st_nxt.cmd.speed.microsteps = st_r.target.speed.microsteps;
                if (st_r.cmd.speed.steps + accelPerUs < st_r.target.speed.steps) begin
                    st_nxt.cmd.speed.steps = st_r.cmd.speed.steps + accelPerUs;
                end else if (st_r.cmd.speed.steps > st_r.target.speed.steps + accelPerUs) begin
                    st_nxt.cmd.speed.steps = st_r.cmd.speed.steps - accelPerUs;
                end else begin
                    st_nxt.cmd.speed.steps = st_r.target.speed.steps;
                end
            end
        end
    end

    // State register; the whole record resets to constants
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '{bst: B_IDLE, ctl: CTL_RESET, readback: CTL_RESET, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the record
    assign ctlSettingsOut = st_r.readback;
    assign ctlReadValid = st_r.readValid;
    assign speedCmd = st_r.cmd;
    assign shiftReq = st_r.shiftPulse;
    assign shiftRight = st_r.shiftDir;
    assign shiftSteps = st_r.ctl.clickShiftSteps;
    assign shiftMicrosteps = st_r.ctl.clickShiftMicrosteps;
    assign stopReq = st_r.stopPulse;
    assign homeReq = st_r.homePulse;
    assign cancelHostCmd = st_r.cancelHost;
    assign joyActive = st_r.joyAct;
    assign tableIndex = st_r.idx;

    // Checks
    a_index_bound: assert property (@(posedge mclk) disable iff (!arst_n)
        st_r.idx <= LAST_INDEX) else $error("table index past last entry");
    a_index_back: assert property (@(posedge mclk) disable iff (!arst_n)
        st_r.idx < $past(st_r.idx) |-> st_r.idx == $past(st_r.idx) - 4'h1
        && $past(st_r.btn[BTN_LEFT])) else $error("bad index decrement");
    a_skip_zero: assert property (@(posedge mclk) disable iff (!arst_n)
        st_r.idx > $past(st_r.idx) |-> st_r.ctl.speedTable[st_r.idx] != '0)
        else $error("index entered empty entry");
    a_debounce_len: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(st_r.btn[BTN_LEFT]) |-> $past(st_r.dbCnt[BTN_LEFT]) > 32'(DEBOUNCE_CYCLES))
        else $error("press accepted too early");
    a_dead_stop: assert property (@(posedge mclk) disable iff (!arst_n)
        st_r.joyMode && !st_r.joyOut |-> !st_r.target.moving)
        else $error("motion inside dead band");
    a_reverse_dir: assert property (@(posedge mclk) disable iff (!arst_n)
        st_r.joyMode && st_r.target.moving |->
        st_r.target.dirRight == (st_r.joyAbove ^ $past(joyCfg.reverse)))
        else $error("joystick direction wrong");
    a_long_exit: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(st_r.joyOut) && $past(st_r.longIn) |-> $past(st_r.outCnt) > 32'(LEAVE_CYCLES))
        else $error("left long dwell too soon");
    a_cancel_host: assert property (@(posedge mclk) disable iff (!arst_n)
        st_r.cancelHost |-> st_r.joyOut && $past(hostBusy) && !$past(st_r.joyOut))
        else $error("cancel without takeover");
    a_home_hold: assert property (@(posedge mclk) disable iff (!arst_n)
        st_r.homePulse |-> $past(st_r.bst) == B_BOTH && $past(bothDown))
        else $error("homing without both held");
    a_hold_speed: assert property (@(posedge mclk) disable iff (!arst_n)
        st_r.bst == B_HOLD && st_r.stage != 4'h0 |->
        st_r.ctl.speedTable[st_r.stage] != '0) else $error("run at empty speed");
    a_jump_noaccel: assert property (@(posedge mclk) disable iff (!arst_n)
        !$past(accelEnable) |-> st_r.cmd == $past(st_r.target))
        else $error("speed not applied at once");
    c_click: cover property (@(posedge mclk) disable iff (!arst_n) st_r.shiftPulse);
    c_stage_up: cover property (@(posedge mclk) disable iff (!arst_n)
        st_r.bst == B_HOLD && st_r.stage == 4'h1);
    c_home: cover property (@(posedge mclk) disable iff (!arst_n) st_r.homePulse);
    c_takeover: cover property (@(posedge mclk) disable iff (!arst_n) st_r.cancelHost);

endmodule

//--- joystick_button_motion_control_bench.sv
`timescale 1ns/1ps

// Self-checking bench with short debounce and hold counts
module joystick_button_motion_control_bench;
    import joystick_button_pkg::*;
    logic mclk, arst_n, pressLeft, pressRight, rd, wr, accelEnable, hostBusy;
    logic btnLeftPin, btnRightPin, ctlReadValid, shiftReq, shiftRight;
    logic stopReq, homeReq, cancelHostCmd, joyActive;
    logic [1:0] activeHigh;
    logic [13:0] stickPos, joyValue;
    logic [31:0] shiftSteps;
    logic [7:0] shiftMicrosteps;
    logic [3:0] tableIndex;
    joy_cfg_t joyCfg;
    ctl_settings_t ctlIn, ctlOut, cfg;
    motion_t speedCmd;
    int num_errors = 0;
    int cmp_count = 0;
    int expIdx = 0;
    logic [31:0] seed = 32'h78c60dca;

    // Fast counts keep the run short
    joystick_button_motion_control #(.DEBOUNCE_CYCLES(20), .LONG_IDLE_CYCLES(200),
        .LEAVE_CYCLES(30), .HOME_CYCLES(100)) u_joystick_button_motion_control (
        .mclk(mclk), .arst_n(arst_n), .joyValue(joyValue), .joyCfg(joyCfg),
        .btnLeftPin(btnLeftPin), .btnRightPin(btnRightPin),
        .writeControlSettingsCmd(wr), .ctlSettingsIn(ctlIn), .readControlSettingsCmd(rd),
        .ctlSettingsOut(ctlOut), .ctlReadValid(ctlReadValid), .accelEnable(accelEnable),
        .accelPerUs(16'h0010), .hostBusy(hostBusy), .speedCmd(speedCmd),
        .shiftReq(shiftReq), .shiftRight(shiftRight), .shiftSteps(shiftSteps),
        .shiftMicrosteps(shiftMicrosteps), .stopReq(stopReq), .homeReq(homeReq),
        .cancelHostCmd(cancelHostCmd), .joyActive(joyActive), .tableIndex(tableIndex));
    user_panel_model u_user_panel_model (.pressLeft(pressLeft), .pressRight(pressRight),
        .stickPos(stickPos), .activeHigh(activeHigh), .btnLeftPin(btnLeftPin),
        .btnRightPin(btnRightPin), .joyValue(joyValue));

    // Free-running system clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // Bench random source
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
    endfunction

    // Verdict and end of run
    task automatic test_done();
        $display("Counts: %0d compares, %0d errors", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Scalar or field result
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    // Settings read back, whole block
    task automatic rd_chk(input ctl_settings_t exp);
        @(posedge mclk);
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        cmp_count++;
        if (ctlReadValid !== 1'b1 || ctlOut !== exp) begin
            num_errors++;
            $display("ERROR %0t settings read back wrong", $time);
        end
    endtask

    // Bounded wait; a miss ends the run
    task automatic wait_for(input int sel, input int lim);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < lim && !hit; i++) begin
            @(posedge mclk);
            #1;
            case (sel)
                0: hit = shiftReq === 1'b1;
                1: hit = speedCmd.moving === 1'b1;
                2: hit = speedCmd.moving === 1'b0;
                3: hit = stopReq === 1'b1;
                4: hit = homeReq === 1'b1;
                5: hit = cancelHostCmd === 1'b1;
                default: hit = speedCmd.speed === cfg.speedTable[1];
            endcase
        end
        if (!hit) begin
            num_errors++;
            $display("ERROR %0t wait %0d timed out", $time, sel);
            test_done();
        end
    endtask

    // Press pattern then release
    task automatic hold(input logic l, input logic r, input int n);
        @(posedge mclk);
        pressLeft <= l;
        pressRight <= r;
        repeat (n) @(posedge mclk);
        pressLeft <= 1'b0;
        pressRight <= 1'b0;
    endtask

    // Main sequence
    initial begin
        {arst_n, pressLeft, pressRight, rd, wr, accelEnable, hostBusy} = '0;
        activeHigh = 2'b00;
        stickPos = 14'h1388;
        joyCfg = '{14'h0000, 14'h1388, 14'h2710, 7'h0a, 4'h0, 1'b0, 1'b1};
        ctlIn = CTL_RESET;
        cfg = CTL_RESET;
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        #1;
        chk(tableIndex, 0, "index at reset");
        rd_chk(CTL_RESET);
        seed = lfsr(seed);
        cfg.speedTable[0].steps = seed[15:0] | 16'h0001;
        cfg.speedTable[1].steps = 16'h0200;
        cfg.stageTimeoutUs[0] = 32'h2;
        seed = lfsr(seed);
        cfg.clickShiftSteps = seed;
        cfg.clickShiftMicrosteps = seed[7:0];
        cfg.clickLengthLimit = 32'h3;
        cfg.btnActiveHigh = 2'b01;
        @(posedge mclk);
        wr <= 1'b1;
        ctlIn <= cfg;
        activeHigh <= cfg.btnActiveHigh;
        @(posedge mclk);
        wr <= 1'b0;
        rd_chk(cfg);
        $display("test settings done");
        hold(1'b0, 1'b1, 10);
        repeat (40) @(posedge mclk);
        chk(tableIndex, 0, "short press");
        // Right, right, left, left against the index model
        for (int k = 0; k < 4; k++) begin
            hold(k > 1, k < 2, 40);
            if (k < 2 && expIdx < 9 && cfg.speedTable[expIdx + 1] != 0) expIdx++;
            if (k > 1 && expIdx > 0) expIdx--;
            repeat (20) @(posedge mclk);
            chk(tableIndex, expIdx, "index step");
        end
        repeat (250) @(posedge mclk);
        hostBusy <= 1'b1;
        stickPos <= 14'h2710;
        repeat (20) @(posedge mclk);
        chk(speedCmd.moving, 0, "early leave");
        wait_for(5, 60);
        wait_for(1, 20);
        chk(joyActive, 1, "stick in control");
        repeat (3) @(posedge mclk);
        chk(speedCmd.speed.steps, cfg.speedTable[0].steps, "full stick");
        chk(speedCmd.dirRight, 1, "stick right");
        joyCfg.reverse <= 1'b1;
        repeat (5) @(posedge mclk);
        chk(speedCmd.dirRight, 0, "reversed");
        stickPos <= 14'h14b4;
        hostBusy <= 1'b0;
        wait_for(2, 20);
        $display("test joystick done");
        joyCfg.enable <= 1'b0;
        hold(1'b1, 1'b0, 60);
        wait_for(0, 60);
        chk(shiftRight, 0, "click dir");
        chk(shiftSteps, cfg.clickShiftSteps, "click steps");
        chk(shiftMicrosteps, cfg.clickShiftMicrosteps, "click micro");
        @(posedge mclk);
        pressRight <= 1'b1;
        wait_for(1, 1000);
        chk(speedCmd.speed, cfg.speedTable[0], "first stage");
        wait_for(7, 600);
        repeat (400) @(posedge mclk);
        chk(speedCmd.speed, cfg.speedTable[1], "kept stage");
        pressRight <= 1'b0;
        wait_for(2, 40);
        $display("test buttons done");
        @(posedge mclk);
        pressLeft <= 1'b1;
        pressRight <= 1'b1;
        wait_for(3, 60);
        wait_for(4, 200);
        hold(1'b0, 1'b0, 50);
        $display("test both buttons done");
        test_done();
    end
endmodule

//--- joystick_button_pkg.sv
package joystick_button_pkg;

    // Clock rate and derived time bases
    localparam int CLK_HZ = 125_000_000;
    localparam int US_PER_S = 1_000_000;
    localparam int MS_PER_S = 1_000;
    localparam int US_CYCLES = CLK_HZ / US_PER_S;
    localparam int DEBOUNCE_MS = 3;
    localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / MS_PER_S);
    localparam int LONG_IDLE_S = 5;
    localparam int LONG_IDLE_CYC = LONG_IDLE_S * CLK_HZ;
    localparam int LEAVE_MS = 100;
    localparam int LEAVE_CYC = LEAVE_MS * (CLK_HZ / MS_PER_S);
    localparam int HOME_HOLD_S = 3;
    localparam int HOME_HOLD_CYC = HOME_HOLD_S * CLK_HZ;

    // Joystick scale and table geometry
    localparam logic [13:0] JOY_FULL_SCALE = 14'h2710;
    localparam int TABLE_LEN = 10;
    localparam logic [3:0] LAST_INDEX = 4'h9;
    localparam logic [10:0] FRAC_ONE = 11'h400;
    localparam int FRAC_BITS = 10;
    localparam logic [3:0] NONLIN_FULL = 4'hf;
    localparam logic [6:0] PCT_FULL = 7'h64;

    // Button index for per-button arrays
    localparam int BTN_LEFT = 0;
    localparam int BTN_RIGHT = 1;

    // One entry of the shared speed table
    typedef struct packed {
        logic [15:0] steps;
        logic [7:0] microsteps;
    } speed_table_entry_t;

    // Button control settings, written and read back as one block
    typedef struct packed {
        speed_table_entry_t [TABLE_LEN-1:0] speedTable;
        logic [TABLE_LEN-1:0][31:0] stageTimeoutUs;
        logic [31:0] clickShiftSteps;
        logic [7:0] clickShiftMicrosteps;
        logic [31:0] clickLengthLimit;
        logic [1:0] btnActiveHigh;
    } ctl_settings_t;

    localparam ctl_settings_t CTL_RESET = '0;

    // Joystick calibration and mode
    typedef struct packed {
        logic [13:0] lowPt;
        logic [13:0] centerPt;
        logic [13:0] highPt;
        logic [6:0] deadZonePct;
        logic [3:0] nonlinearity;
        logic reverse;
        logic enable;
    } joy_cfg_t;

    // Speed request toward the motion generator
    typedef struct packed {
        logic moving;
        logic dirRight;
        speed_table_entry_t speed;
    } motion_t;

    // Button sequencer states
    typedef enum logic [4:0] {
        B_IDLE = 5'h01,
        B_PRESS = 5'h02,
        B_HOLD = 5'h04,
        B_BOTH = 5'h08,
        B_WAIT = 5'h10
    } btn_state_t;

endpackage

//--- user_panel_model.sv
`timescale 1ns/1ps

// Operator side: two push buttons and an analog stick
module user_panel_model (
    // Operator intent
    input wire logic pressLeft,
    input wire logic pressRight,
    input wire logic [13:0] stickPos,
    input wire logic [1:0] activeHigh,
    // Pins toward the block
    output logic btnLeftPin,
    output logic btnRightPin,
    output logic [13:0] joyValue
);
    // Pressed button drives its active level, idle the other level
    assign btnLeftPin = pressLeft ~^ activeHigh[0];
    assign btnRightPin = pressRight ~^ activeHigh[1];
    // Stick reading already scaled 0..10000
    assign joyValue = stickPos;
endmodule
